// [bench/mem_model.sv]
// file: zero-wait program and data memory on the core's address bus
`timescale 1ns/1ps
module mem_model
  import addr_former_pkg::*;
(
  input  wire logic     clock,
  input  wire mem_req_t bus,
  output logic [7:0]    rdata
);
  // ----------------------------------------------------------------
  // storage, filled with an opcode that has no modelled mode
  // ----------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] junk_q;
  initial begin
    foreach (mem[i]) mem[i] = 8'h01;
    junk_q = 8'hA5;
  end
  // writes land on the edge, so read-back of the same place sees new data
  always @(posedge clock) begin
    junk_q <= ~junk_q;
    if (bus.wr) mem[bus.addr] <= bus.wdata;
  end
  // an idle bus shows a changing pattern, never the last byte
  assign rdata = bus.rd ? mem[bus.addr] : junk_q;
endmodule : mem_model

// [bench/operand_address_former_test.sv]
// file: self-checking bench for the operand address former
`timescale 1ns/1ps
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module operand_address_former_test;
  import addr_former_pkg::*;
  logic        clock;
  logic        rst_b;
  logic [7:0]  rdata;
  logic        zp_remap_we;
  logic [1:0]  zp_remap_val;
  mem_req_t    bus;
  logic [15:0] eff_addr;
  logic [15:0] operand;
  logic [2:0]  mode;
  logic [1:0]  page;
  logic [2:0]  instr_len;
  logic        illegal_mode;
  logic [1:0]  zp_owner;
  logic        done;
  int          num_errors;
  int          checks_done;
  int          gap;
  operand_address_former i_operand_address_former (.clock(clock), .rst_b(rst_b),
    .rdata(rdata), .zp_remap_we(zp_remap_we), .zp_remap_val(zp_remap_val), .bus(bus),
    .eff_addr(eff_addr), .operand(operand), .mode(mode), .page(page),
    .instr_len(instr_len), .illegal_mode(illegal_mode), .zp_owner(zp_owner), .done(done));
  mem_model i_mem_model (.clock(clock), .bus(bus), .rdata(rdata));
  // ----------------------------------------------------------------
  // clock and helpers
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic finish_test();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  // bounded wait for the next done pulse; gap counts the cycles taken
  task automatic wait_done();
    gap = 0;
    do begin
      @(posedge clock);
      #1;
      gap++;
      if (gap > 30) begin
        num_errors++;
        finish_test();
      end
    end while (done !== 1'b1);
  endtask : wait_done
  // ----------------------------------------------------------------
  // scenarios, in program order
  // ----------------------------------------------------------------
  task automatic stream_ops();
    wait_done();
    `CHECK(mode, OPERAND_IN_STREAM_MODE)
    `CHECK(operand[7:0], 8'h16)
    `CHECK(instr_len, 3'h2)
    wait_done();
    `CHECK(operand, 16'h1234)
    `CHECK(instr_len, 3'h3)
    wait_done();
    `CHECK(page, PAGE_2)
    `CHECK(operand, 16'h5678)
    `CHECK(instr_len, 3'h4)
  endtask : stream_ops
  task automatic full_vs_short();
    int full_gap;
    wait_done();
    full_gap = gap;
    `CHECK(mode, FULL_ADDRESS_MODE)
    `CHECK(eff_addr, 16'h2000)
    `CHECK(instr_len, 3'h3)
    wait_done();
    `CHECK(mode, SHORT_ADDRESS_MODE)
    `CHECK(eff_addr, 16'h0080)
    `CHECK(eff_addr[15:8], ZERO_PAGE_HIGH)
    `CHECK(instr_len, 3'h2)
    `CHECK(full_gap, gap + 1)
  endtask : full_vs_short
  task automatic rmw_op();
    wait_done();
    `CHECK(mode, RMW_FULL)
    `CHECK(eff_addr, 16'h3000)
    `CHECK(i_mem_model.mem[16'h3000], 8'h7F)
  endtask : rmw_op
  task automatic prebyte_full();
    wait_done();
    `CHECK(page, PAGE_3)
    `CHECK(mode, FULL_ADDRESS_MODE)
    `CHECK(eff_addr, 16'h4000)
    `CHECK(instr_len, 3'h4)
    wait_done();
    `CHECK(page, PAGE_4)
    `CHECK(mode, OPERAND_IN_STREAM_MODE)
    `CHECK(operand, 16'hABCD)
    `CHECK(instr_len, 3'h4)
  endtask : prebyte_full
  task automatic refused_op();
    wait_done();
    `CHECK(illegal_mode, 1'b1)
  endtask : refused_op
  task automatic remap_zero_page();
    `CHECK(zp_owner, ZP_OWNER_RESET)
    for (int v = 1; v >= 0; v--) begin
      zp_remap_val = 2'(v + 1);
      zp_remap_we  = 1'b1;
      @(posedge clock);
      #1;
      zp_remap_we = 1'b0;
      @(posedge clock);
      #1;
      `CHECK(zp_owner, 2'(v + 1))
    end
    // a second reset in mid-run must hand the zero page back to RAM
    rst_b = 1'b0;
    @(posedge clock);
    #1;
    rst_b = 1'b1;
    @(posedge clock);
    #1;
    `CHECK(zp_owner, ZP_OWNER_RESET)
  endtask : remap_zero_page
  // ----------------------------------------------------------------
  // program load, reset and main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] prog [0:25];
    prog = '{8'h86, 8'h16, 8'hCC, 8'h12, 8'h34, 8'h18, 8'hCE, 8'h56, 8'h78, 8'hB6, 8'h20,
             8'h00, 8'h96, 8'h80, 8'h7C, 8'h30, 8'h00, 8'h1A, 8'hB3, 8'h40, 8'h00,
             8'hCD, 8'h8C, 8'hAB, 8'hCD, 8'h01};
    num_errors   = 0;
    checks_done  = 0;
    rst_b        = 1'b0;
    zp_remap_we  = 1'b0;
    zp_remap_val = 2'h0;
    #1;
    foreach (prog[i]) i_mem_model.mem[i] = prog[i];
    i_mem_model.mem[16'h3000] = 8'h7E;
    repeat (10) @(posedge clock);
    #1;
    rst_b = 1'b1;
    stream_ops();
    full_vs_short();
    rmw_op();
    prebyte_full();
    refused_op();
    remap_zero_page();
    finish_test();
  end
endmodule : operand_address_former_test

// [pkg/addr_former_pkg.sv]
// package: constants and types for the operand address former
package addr_former_pkg;

  // ----------------------------------------------------------------
  // page-select prebytes, opcode range and nibble values, zero-page high byte and reset vector
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE2_PREBYTE  = 8'h18;
  localparam logic [7:0] PAGE3_PREBYTE  = 8'h1A;
  localparam logic [7:0] PAGE4_PREBYTE  = 8'hCD;
  localparam logic [7:0] RMW_LO         = 8'h40;
  localparam logic [7:0] RMW_HI         = 8'h7F;
  localparam logic [3:0] JUMP_LOW_NIB   = 4'hE;
  localparam logic [3:0] TEST_LOW_NIB   = 4'hD;
  localparam logic [7:0] ZERO_PAGE_HIGH = 8'h00;
  localparam logic [15:0] RESET_VECTOR  = 16'h0000;

  // ----------------------------------------------------------------
  // mode codes and zero-page owners
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PAGE_1, PAGE_2, PAGE_3, PAGE_4} page_t;
  typedef enum logic [2:0] {
    MODE_NONE, OPERAND_IN_STREAM_MODE, FULL_ADDRESS_MODE, SHORT_ADDRESS_MODE, RMW_FULL
  } addr_mode_t;
  typedef enum logic [1:0] {ZP_RAM, ZP_REGS, ZP_EXTERNAL} zp_owner_t;
  localparam logic [1:0] ZP_OWNER_RESET = 2'h0;

  // memory bus carrier
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } mem_req_t;

endpackage : addr_former_pkg

// [rtl/operand_address_former.sv]
// module: operand fetch and effective-address formation sequencer
`timescale 1ns/1ps
module operand_address_former
  import addr_former_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [7:0]  rdata,
  input  wire logic        zp_remap_we,
  input  wire logic [1:0]  zp_remap_val,
  output mem_req_t         bus,
  output logic [15:0]      eff_addr,
  output logic [15:0]      operand,
  output logic [2:0]       mode,
  output logic [1:0]       page,
  output logic [2:0]       instr_len,
  output logic             illegal_mode,
  output logic [1:0]       zp_owner,
  output logic             done
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  // mode from opcode bits 7 and 5:4 outside 40-7F: columns 8/C imm, 9/D short, B/F full
  function automatic addr_mode_t decode_mode(input logic [7:0] op);
    addr_mode_t m;
    m = MODE_NONE;
    if (op >= RMW_LO && op <= RMW_HI) begin
      // column 7 is the full-address memory form; no short form exists
      if (op[7:4] == 4'h7 && op[3:0] != JUMP_LOW_NIB && op[3:0] != TEST_LOW_NIB) begin
        m = RMW_FULL;
      end else if (op[7:4] == 4'h7) begin
        m = FULL_ADDRESS_MODE;
      end
    end else if (op[7]) begin
      unique case (op[5:4])
        2'b00: m = OPERAND_IN_STREAM_MODE;
        2'b01: m = SHORT_ADDRESS_MODE;
        2'b11: m = FULL_ADDRESS_MODE;
        default: m = MODE_NONE;
      endcase
    end
    return m;
  endfunction : decode_mode

  // 16-bit destinations: column 3 (subd/addd/cpd), C (cpx/ldd), E (lds/ldx)
  function automatic logic wide_dest(input logic [7:0] op);
    return (op[3:0] == 4'h3) || (op[3:0] == 4'hC) || (op[3:0] == 4'hE);
  endfunction : wide_dest

  function automatic logic is_prebyte(input logic [7:0] b);
    return b == PAGE2_PREBYTE || b == PAGE3_PREBYTE || b == PAGE4_PREBYTE;
  endfunction : is_prebyte

  // ----------------------------------------------------------------
  // fetch sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_OPCODE, S_OPCODE2, S_BYTE1, S_BYTE2, S_READ, S_WRITE, S_DONE
  } state_t;

  state_t      state_q, state_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0]  op_q, op_d;
  page_t       page_q, page_d;
  addr_mode_t  mode_q, mode_d;
  logic [15:0] ea_q, ea_d;
  logic [15:0] operand_q, operand_d;
  logic [2:0]  len_q, len_d;
  logic        wide_q, wide_d;
  logic        ill_q, ill_d;
  logic [1:0]  zp_q, zp_d;
  logic        done_q, done_d;
  mem_req_t    bus_q, bus_d;

  // next-state and bus request computation
  always_comb begin
    addr_mode_t m;
    m         = decode_mode(rdata);
    state_d   = state_q;
    pc_d      = pc_q;
    op_d      = op_q;
    page_d    = page_q;
    mode_d    = mode_q;
    ea_d      = ea_q;
    operand_d = operand_q;
    len_d     = len_q;
    wide_d    = wide_q;
    ill_d     = ill_q;
    done_d    = 1'b0;
    zp_d      = zp_remap_we ? zp_remap_val : zp_q;
    bus_d     = '{addr: pc_q, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
    unique case (state_q)
      S_OPCODE: begin
        pc_d   = pc_q + 16'h0001;
        page_d = PAGE_1;
        len_d  = 3'd1;
        ill_d  = 1'b0;
        op_d   = rdata;
        if (is_prebyte(rdata)) begin
          // page selection by prebyte; second opcode byte follows
          page_d  = (rdata == PAGE2_PREBYTE) ? PAGE_2 :
                    (rdata == PAGE3_PREBYTE) ? PAGE_3 : PAGE_4;
          len_d   = 3'd2;
          state_d = S_OPCODE2;
        end else begin
          mode_d  = m;
          wide_d  = wide_dest(rdata);
          state_d = (m == MODE_NONE) ? S_DONE : S_BYTE1;
          ill_d   = (m == MODE_NONE);
        end
        bus_d.addr = pc_d;
      end
      S_OPCODE2: begin
        pc_d    = pc_q + 16'h0001;
        op_d    = rdata;
        mode_d  = m;
        wide_d  = wide_dest(rdata);
        // length already counts prebyte and opcode, so it is not bumped here
        ill_d   = (m == MODE_NONE);
        state_d = (m == MODE_NONE) ? S_DONE : S_BYTE1;
        bus_d.addr = pc_d;
      end
      S_BYTE1: begin
        pc_d  = pc_q + 16'h0001;
        len_d = len_q + 3'd1;
        unique case (mode_q)
          OPERAND_IN_STREAM_MODE: begin
            operand_d = {8'h00, rdata};
            ea_d      = pc_q;
            state_d   = wide_q ? S_BYTE2 : S_DONE;
          end
          SHORT_ADDRESS_MODE: begin
            ea_d    = {ZERO_PAGE_HIGH, rdata};
            state_d = S_READ;
          end
          default: begin
            ea_d    = {rdata, 8'h00};
            state_d = S_BYTE2;
          end
        endcase
        bus_d.addr = pc_d;
      end
      S_BYTE2: begin
        pc_d  = pc_q + 16'h0001;
        len_d = len_q + 3'd1;
        if (mode_q == OPERAND_IN_STREAM_MODE) begin
          operand_d = {operand_q[7:0], rdata};
          state_d   = S_DONE;
          bus_d.addr = pc_d;
        end else begin
          ea_d    = {ea_q[15:8], rdata};
          state_d = S_READ;
          bus_d.addr = {ea_q[15:8], rdata};
        end
      end
      S_READ: begin
        operand_d = {8'h00, rdata};
        if (mode_q == RMW_FULL) begin
          state_d = S_WRITE;
          bus_d   = '{addr: ea_q, wdata: rdata + 8'h01, rd: 1'b0, wr: 1'b1};
        end else begin
          state_d = S_DONE;
        end
      end
      S_WRITE: begin
        state_d = S_DONE;
      end
      S_DONE: begin
        done_d  = 1'b1;
        state_d = S_OPCODE;
      end
      default: state_d = S_OPCODE;
    endcase
    // bus points at the effective address once formed in short mode
    if (state_q == S_BYTE1 && mode_q == SHORT_ADDRESS_MODE) begin
      bus_d.addr = {ZERO_PAGE_HIGH, rdata};
    end
  end

  // registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= S_OPCODE;
      pc_q      <= RESET_VECTOR;
      op_q      <= 8'h00;
      page_q    <= PAGE_1;
      mode_q    <= MODE_NONE;
      ea_q      <= 16'h0000;
      operand_q <= 16'h0000;
      len_q     <= 3'd0;
      wide_q    <= 1'b0;
      ill_q     <= 1'b0;
      zp_q      <= ZP_OWNER_RESET;
      done_q    <= 1'b0;
      bus_q     <= '{addr: RESET_VECTOR, wdata: 8'h00, rd: 1'b1, wr: 1'b0};
    end else begin
      state_q   <= state_d;
      pc_q      <= pc_d;
      op_q      <= op_d;
      page_q    <= page_d;
      mode_q    <= mode_d;
      ea_q      <= ea_d;
      operand_q <= operand_d;
      len_q     <= len_d;
      wide_q    <= wide_d;
      ill_q     <= ill_d;
      zp_q      <= zp_d;
      done_q    <= done_d;
      bus_q     <= bus_d;
    end
  end

  // outputs straight from flip-flops
  assign bus          = bus_q;
  assign eff_addr     = ea_q;
  assign operand      = operand_q;
  assign mode         = mode_q;
  assign page         = page_q;
  assign instr_len    = len_q;
  assign illegal_mode = ill_q;
  assign zp_owner     = zp_q;
  assign done         = done_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_short_high_zero: assert property (@(posedge clock) disable iff (!rst_b)
    (done && mode == SHORT_ADDRESS_MODE) |-> eff_addr[15:8] == ZERO_PAGE_HIGH)
    else $error("short address high byte not zero");
  a_short_len: assert property (@(posedge clock) disable iff (!rst_b)
    (done && mode == SHORT_ADDRESS_MODE && page == PAGE_1) |-> instr_len == 3'd2)
    else $error("short instruction length wrong");
  a_full_len: assert property (@(posedge clock) disable iff (!rst_b)
    (done && mode == FULL_ADDRESS_MODE) |-> instr_len == ((page == PAGE_1) ? 3'd3 : 3'd4))
    else $error("full instruction length wrong");
  a_stream_len: assert property (@(posedge clock) disable iff (!rst_b)
    (done && mode == OPERAND_IN_STREAM_MODE) |-> instr_len inside {3'd2, 3'd3, 3'd4})
    else $error("stream instruction length wrong");
  a_wb_same_addr: assert property (@(posedge clock) disable iff (!rst_b)
    bus.wr |-> bus.addr == eff_addr && $past(bus.rd))
    else $error("write-back address differs");
  a_reset_zp_ram: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(rst_b) |-> zp_owner == ZP_OWNER_RESET)
    else $error("zero page not ram after reset");
  a_page_sel: assert property (@(posedge clock) disable iff (!rst_b)
    (state_q == S_OPCODE && rdata == PAGE2_PREBYTE) |=> page == PAGE_2)
    else $error("prebyte page not selected");
  a_rmw_mode: assert property (@(posedge clock) disable iff (!rst_b)
    (done && op_q inside {[RMW_LO:RMW_HI]}) |-> mode != SHORT_ADDRESS_MODE)
    else $error("short form in read-modify-write range");

  // named steps: a first-page opcode in the short or full form, taken
  // with no prebyte ahead of it; done then follows a fixed count later
  sequence s_short_op;
    state_q == S_OPCODE && !is_prebyte(rdata) && decode_mode(rdata) == SHORT_ADDRESS_MODE;
  endsequence
  sequence s_full_op;
    state_q == S_OPCODE && !is_prebyte(rdata) && decode_mode(rdata) == FULL_ADDRESS_MODE;
  endsequence

  // the short form drops one address fetch, so it ends one cycle sooner
  a_short_cycles: assert property (@(posedge clock) disable iff (!rst_b)
    s_short_op |-> ##3 !done ##1 done)
    else $error("short form cycle count wrong");
  a_full_cycles: assert property (@(posedge clock) disable iff (!rst_b)
    s_full_op |-> ##4 !done ##1 done)
    else $error("full form cycle count wrong");
  // effective address and operand forming
  a_ea_on_bus: assert property (@(posedge clock) disable iff (!rst_b)
    (state_q == S_READ) |-> bus.addr == ea_q && bus.rd)
    else $error("effective address not on bus");
  a_stream_narrow: assert property (@(posedge clock) disable iff (!rst_b)
    (state_q == S_BYTE1 && mode_q == OPERAND_IN_STREAM_MODE && !wide_q)
      |=> operand == {8'h00, $past(rdata)})
    else $error("narrow stream operand wrong");
  a_stream_wide: assert property (@(posedge clock) disable iff (!rst_b)
    (state_q == S_BYTE2 && mode_q == OPERAND_IN_STREAM_MODE)
      |=> operand == {$past(operand[7:0]), $past(rdata)})
    else $error("wide stream operand wrong");
  a_full_high_first: assert property (@(posedge clock) disable iff (!rst_b)
    (state_q == S_BYTE1 && mode_q inside {FULL_ADDRESS_MODE, RMW_FULL})
      |=> eff_addr[15:8] == $past(rdata))
    else $error("first address byte not high byte");

endmodule : operand_address_former
